// file: pkg/port_cfg_pkg.sv
// constants and carrier types for the port analog/redirect configuration
package port_cfg_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [19:0] ADDR_PORT0_AS = 20'hF_0060;
    localparam logic [19:0] ADDR_PORT3_AS = 20'h F_0063;
    localparam logic [19:0] ADDR_PORT10_AS = 20'h F_006A;
    localparam logic [19:0] ADDR_PORT11_AS = 20'h F_006B;
    localparam logic [19:0] ADDR_PORT12_AS = 20'h F_006C;
    localparam logic [19:0] ADDR_PORT14_AS = 20'h F_006E;
    localparam logic [19:0] ADDR_GROUP_CFG = 20'h F_0076;
    localparam logic [19:0] ADDR_IN_BLOCK = 20'h F_007D;
    localparam logic [19:0] ADDR_REDIRECT = 20'h F_0077;

    // ------------------------------------------------------------
    // mounted-bit masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_PORT0 = 8'h0F;
    localparam logic [7:0] MASK_PORT3 = 8'hE0;
    localparam logic [7:0] MASK_PORT10 = 8'h01;
    localparam logic [7:0] MASK_PORT11 = 8'hE0;
    localparam logic [7:0] MASK_PORT12 = 8'h01;
    localparam logic [7:0] MASK_PORT14 = 8'h80;
    localparam logic [7:0] MASK_GROUP = 8'h0F;
    localparam logic [7:0] MASK_REDIRECT = 8'h3F;
    localparam logic [7:0] MASK_IN_BLOCK = 8'h01;
    localparam logic [7:0] RST_ANALOG_SEL = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;

    localparam int GROUP_PINS = 15;
    localparam int NUM_AS = 6;
    localparam int NUM_FUNC = 6;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_op;
        logic [2:0] bit_idx;
        logic [19:0] addr;
        logic [7:0] wdata;
    } bus_req_type;

    typedef struct packed {
        logic [NUM_AS-1:0][7:0] analog_sel;
        logic [7:0] group_cfg;
        logic [7:0] redirect;
        logic [7:0] in_block;
        logic [NUM_FUNC-1:0] redirect_live;
        logic [7:0] rdata;
    } state_type;

endpackage

// file: rtl/port_analog_redirect_config.sv
// port analog select, group config, redirection and input-block registers
module port_analog_redirect_config (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // register access
    input wire port_cfg_pkg::bus_req_type bus_i,
    output logic [7:0] rdata_o,
    // function enables from peripherals
    input wire logic [port_cfg_pkg::NUM_FUNC-1:0] func_enable_i,
    // port state used for data read-back
    input wire logic [port_cfg_pkg::GROUP_PINS-1:0] group_dir_in_i,
    input wire logic [port_cfg_pkg::GROUP_PINS-1:0] group_pin_i,
    input wire logic [7:0] sec_pin_i,
    input wire logic [7:0] sec_open_drain_i,
    // configuration outputs
    output logic [port_cfg_pkg::NUM_AS-1:0][7:0] analog_sel_o,
    output logic [port_cfg_pkg::GROUP_PINS-1:0] group_analog_o,
    output logic [port_cfg_pkg::NUM_FUNC-1:0] redirect_o,
    output logic sec_input_enable_o,
    // port data read-back
    output logic [port_cfg_pkg::GROUP_PINS-1:0] group_read_o,
    output logic [7:0] sec_read_o
);

    port_cfg_pkg::state_type state_reg;
    port_cfg_pkg::state_type state_next;

    logic [port_cfg_pkg::NUM_AS-1:0][19:0] as_addr;
    logic [port_cfg_pkg::NUM_AS-1:0][7:0] as_mask;
    logic [port_cfg_pkg::GROUP_PINS-1:0] group_analog;
    logic [7:0] sec_sync1_reg;
    logic [7:0] sec_sync2_reg;
    logic [port_cfg_pkg::GROUP_PINS-1:0] grp_sync1_reg;
    logic [port_cfg_pkg::GROUP_PINS-1:0] grp_sync2_reg;

    assign as_addr = {port_cfg_pkg::ADDR_PORT14_AS,
        port_cfg_pkg::ADDR_PORT12_AS, port_cfg_pkg::ADDR_PORT11_AS,
        port_cfg_pkg::ADDR_PORT10_AS, port_cfg_pkg::ADDR_PORT3_AS,
        port_cfg_pkg::ADDR_PORT0_AS};
    assign as_mask = {port_cfg_pkg::MASK_PORT14, port_cfg_pkg::MASK_PORT12,
        port_cfg_pkg::MASK_PORT11, port_cfg_pkg::MASK_PORT10,
        port_cfg_pkg::MASK_PORT3, port_cfg_pkg::MASK_PORT0};

    // ------------------------------------------------------------
    // group code decode
    // ------------------------------------------------------------
    // code zero all analog, one all digital
    genvar g;
    generate
        for (g = 0; g < port_cfg_pkg::GROUP_PINS; g++) begin : g_grp
            assign group_analog[g] = (state_reg.group_cfg[3:0] == 4'h0) ||
                ((state_reg.group_cfg[3:0] >= 4'h2) &&
                 (5'(g) <= 5'(state_reg.group_cfg[3:0]) - 5'h02));
        end
    endgenerate

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.rdata = 8'h00;
        for (int i = 0; i < port_cfg_pkg::NUM_AS; i++) begin
            if (bus_i.addr == as_addr[i]) begin
                if (bus_i.wr) begin
                    if (bus_i.bit_op) begin
                        state_next.analog_sel[i][bus_i.bit_idx] =
                            bus_i.wdata[0];
                    end else begin
                        state_next.analog_sel[i] = bus_i.wdata;
                    end
                    state_next.analog_sel[i] =
                        state_next.analog_sel[i] | ~as_mask[i];
                end
                if (bus_i.rd) begin
                    state_next.rdata = state_reg.analog_sel[i];
                end
            end
        end
        if (bus_i.addr == port_cfg_pkg::ADDR_GROUP_CFG) begin
            // byte writes only, upper nibble zero
            if (bus_i.wr && !bus_i.bit_op) begin
                state_next.group_cfg =
                    bus_i.wdata & port_cfg_pkg::MASK_GROUP;
            end
            if (bus_i.rd) begin
                state_next.rdata = state_reg.group_cfg;
            end
        end else if (bus_i.addr == port_cfg_pkg::ADDR_REDIRECT) begin
            // byte writes only, bits 7:6 zero
            if (bus_i.wr && !bus_i.bit_op) begin
                state_next.redirect =
                    bus_i.wdata & port_cfg_pkg::MASK_REDIRECT;
            end
            if (bus_i.rd) begin
                state_next.rdata = state_reg.redirect;
            end
        end else if (bus_i.addr == port_cfg_pkg::ADDR_IN_BLOCK) begin
            // bit or byte write, bit 0 only
            if (bus_i.wr && bus_i.bit_op) begin
                if (bus_i.bit_idx == 3'h0) begin
                    state_next.in_block[0] = bus_i.wdata[0];
                end
            end else if (bus_i.wr) begin
                state_next.in_block =
                    bus_i.wdata & port_cfg_pkg::MASK_IN_BLOCK;
            end
            if (bus_i.rd) begin
                state_next.rdata = state_reg.in_block;
            end
        end
        for (int f = 0; f < port_cfg_pkg::NUM_FUNC; f++) begin
            if (!func_enable_i[f]) begin
                state_next.redirect_live[f] = state_next.redirect[f];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // analog select comes up all ones
            for (int i = 0; i < port_cfg_pkg::NUM_AS; i++) begin
                state_reg.analog_sel[i] <= port_cfg_pkg::RST_ANALOG_SEL;
            end
            state_reg.group_cfg <= port_cfg_pkg::RST_ZERO;
            state_reg.redirect <= port_cfg_pkg::RST_ZERO;
            state_reg.in_block <= port_cfg_pkg::RST_ZERO;
            state_reg.redirect_live <= '0;
            state_reg.rdata <= port_cfg_pkg::RST_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // pin level synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sec_sync1_reg <= 8'h00;
            sec_sync2_reg <= 8'h00;
            grp_sync1_reg <= '0;
            grp_sync2_reg <= '0;
        end else begin
            sec_sync1_reg <= sec_pin_i;
            sec_sync2_reg <= sec_sync1_reg;
            grp_sync1_reg <= group_pin_i;
            grp_sync2_reg <= grp_sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // set bit routes pin to analog
    assign analog_sel_o = state_reg.analog_sel;
    assign group_analog_o = group_analog;
    assign redirect_o = state_reg.redirect_live;
    assign sec_input_enable_o = ~state_reg.in_block[0];
    assign rdata_o = state_reg.rdata;

    // blocked reads one, open drain zero
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            if (state_reg.in_block[0]) begin
                sec_read_o[b] = ~sec_open_drain_i[b];
            end else begin
                sec_read_o[b] = sec_sync2_reg[b];
            end
        end
    end

    assign group_read_o = grp_sync2_reg &
        ~(group_analog & group_dir_in_i);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_GROUP_ZERO_ANALOG: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state_reg.group_cfg == 8'h00) |-> (group_analog_o == 15'h7FFF))
        else $error("group code zero not all analog");
    AST_GROUP_ONE_DIGITAL: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state_reg.group_cfg == 8'h01) |-> (group_analog_o == 15'h0000))
        else $error("group code one not all digital");
    AST_GROUP_UPPER_ZERO: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        state_reg.group_cfg[7:4] == 4'h0)
        else $error("group upper bits not zero");
    AST_REDIRECT_TOP_ZERO: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        state_reg.redirect[7:6] == 2'b00)
        else $error("redirect top bits not zero");
    AST_BLOCK_ONE_BIT: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        state_reg.in_block[7:1] == 7'h00)
        else $error("input block upper bits set");
    AST_BLOCK_GATES: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        sec_input_enable_o != state_reg.in_block[0])
        else $error("input enable not tied to block bit");
    AST_PORT0_UNMOUNTED: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        state_reg.analog_sel[0][7:4] == 4'hF)
        else $error("unmounted select bits not one");
    AST_REDIRECT_HELD: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (func_enable_i[0] && $past(func_enable_i[0]))
        |-> $stable(redirect_o[0]))
        else $error("redirect changed while function enabled");
    AST_ANALOG_READ_ZERO: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (group_analog_o[0] && group_dir_in_i[0]) |-> !group_read_o[0])
        else $error("analog input read not zero");
    AST_BLOCKED_READ: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        state_reg.in_block[0] |-> (sec_read_o == ~sec_open_drain_i))
        else $error("blocked read value wrong");
    AST_BYTE_WRITE: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.wr && !bus_i.bit_op &&
         bus_i.addr == port_cfg_pkg::ADDR_PORT0_AS)
        |=> (state_reg.analog_sel[0][3:0] == $past(bus_i.wdata[3:0])))
        else $error("analog select byte write lost");
    AST_SELECT_BIT_WRITE: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.wr && bus_i.bit_op && bus_i.bit_idx == 3'h2 &&
         bus_i.addr == port_cfg_pkg::ADDR_PORT0_AS)
        |=> (state_reg.analog_sel[0][2] == $past(bus_i.wdata[0])))
        else $error("analog select bit write lost");
    AST_SELECT_READBACK: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.rd && bus_i.addr == port_cfg_pkg::ADDR_PORT0_AS)
        |=> (rdata_o == $past(analog_sel_o[0])))
        else $error("analog select read back wrong");
    AST_RESET_SELECT: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !$past(resetn_i) |-> (analog_sel_o ==
            {port_cfg_pkg::NUM_AS{port_cfg_pkg::RST_ANALOG_SEL}}))
        else $error("analog select not all ones after reset");
    AST_RESET_OTHERS: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        !$past(resetn_i) |-> (state_reg.group_cfg == 8'h00 &&
            state_reg.redirect == 8'h00 && state_reg.in_block == 8'h00))
        else $error("zero-reset register not zero after reset");
    AST_GROUP_CODE_TWO: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state_reg.group_cfg == 8'h02) |-> (group_analog_o == 15'h0001))
        else $error("group code two not channel zero only");
    AST_GROUP_CODE_EIGHT: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state_reg.group_cfg == 8'h08) |-> (group_analog_o == 15'h007F))
        else $error("group code eight split wrong");
    AST_GROUP_CODE_MAX: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (state_reg.group_cfg == 8'h0F) |-> (group_analog_o == 15'h3FFF))
        else $error("group code fifteen split wrong");
    AST_GROUP_TOP_CHANNEL: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        group_analog_o[14] |-> (state_reg.group_cfg == 8'h00))
        else $error("top group channel analog with nonzero code");
    AST_GROUP_BYTE_WRITE: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.wr && !bus_i.bit_op &&
         bus_i.addr == port_cfg_pkg::ADDR_GROUP_CFG)
        |=> (state_reg.group_cfg ==
             ($past(bus_i.wdata) & port_cfg_pkg::MASK_GROUP)))
        else $error("group code byte write lost");
    AST_GROUP_BIT_IGNORED: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.wr && bus_i.bit_op &&
         bus_i.addr == port_cfg_pkg::ADDR_GROUP_CFG)
        |=> $stable(state_reg.group_cfg))
        else $error("group code changed by bit write");
    AST_GROUP_READBACK: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.rd && bus_i.addr == port_cfg_pkg::ADDR_GROUP_CFG)
        |=> (rdata_o == $past(state_reg.group_cfg)))
        else $error("group code read back wrong");
    AST_REDIRECT_BYTE_WRITE: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.wr && !bus_i.bit_op &&
         bus_i.addr == port_cfg_pkg::ADDR_REDIRECT)
        |=> (state_reg.redirect ==
             ($past(bus_i.wdata) & port_cfg_pkg::MASK_REDIRECT)))
        else $error("redirect byte write lost");
    AST_REDIRECT_BIT_IGNORED: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.wr && bus_i.bit_op &&
         bus_i.addr == port_cfg_pkg::ADDR_REDIRECT)
        |=> $stable(state_reg.redirect))
        else $error("redirect changed by bit write");
    AST_BLOCK_BYTE_WRITE: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.wr && !bus_i.bit_op &&
         bus_i.addr == port_cfg_pkg::ADDR_IN_BLOCK)
        |=> (state_reg.in_block ==
             ($past(bus_i.wdata) & port_cfg_pkg::MASK_IN_BLOCK)))
        else $error("input block byte write lost");
    AST_BLOCK_BIT_WRITE: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (bus_i.wr && bus_i.bit_op && bus_i.bit_idx == 3'h0 &&
         bus_i.addr == port_cfg_pkg::ADDR_IN_BLOCK)
        |=> (state_reg.in_block[0] == $past(bus_i.wdata[0])))
        else $error("input block bit write lost");
    AST_ANALOG_READ_ALL: assert property (
        @(posedge clk_sys_i) disable iff (!resetn_i)
        (group_analog_o & group_dir_in_i & group_read_o) == 15'h0000)
        else $error("analog input pin read not zero");

    // ------------------------------------------------------------
    // per-function and per-register checks
    // ------------------------------------------------------------
    // a move under a running function would glitch its pins
    for (genvar f = 0; f < port_cfg_pkg::NUM_FUNC; f++) begin : g_redir_chk
        AST_REDIRECT_FOLLOWS: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            !func_enable_i[f] |=> (redirect_o[f] == state_reg.redirect[f]))
            else $error("idle function placement not following register");
        AST_REDIRECT_FROZEN: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            (func_enable_i[f] && $past(func_enable_i[f]))
            |-> $stable(redirect_o[f]))
            else $error("running function placement changed");
    end
    for (genvar u = 0; u < port_cfg_pkg::NUM_AS; u++) begin : g_unmount_chk
        AST_SELECT_UNMOUNTED: assert property (
            @(posedge clk_sys_i) disable iff (!resetn_i)
            (analog_sel_o[u] | as_mask[u]) == 8'hFF)
            else $error("unmounted select bit cleared");
    end

endmodule

// file: sim/pin_side_model.sv
// pin-side model: pad levels and the secondary supply of the port pins
module pin_side_model (
    // clock
    input wire logic clk_sys_i,
    // bench controls
    input wire logic supply_on_i,
    input wire logic [14:0] group_level_i,
    input wire logic [7:0] sec_level_i,
    // pad levels
    output logic [14:0] group_pin_o,
    output logic [7:0] sec_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] float_reg = 8'h5A;
    // unpowered pads float: toggle so no stale level passes by luck
    always @(posedge clk_sys_i) float_reg <= ~float_reg;
    assign group_pin_o = group_level_i;
    assign sec_pin_o = supply_on_i ? sec_level_i : float_reg;
endmodule

// file: sim/testbench.sv
// self-checking bench for the port analog/redirect configuration block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [19:0] a;
        logic [7:0] d;
        logic b;
        logic [2:0] i;
        logic [7:0] e;
    } row_type;
    logic clk_sys_i, resetn_i, supply_on;
    port_cfg_pkg::bus_req_type bus_i;
    logic [7:0] rdata_o, sec_pin_i, sec_open_drain_i, sec_read_o, v;
    logic [5:0] func_enable_i, redirect_o;
    logic [14:0] group_dir_in_i, group_pin_i, group_analog_o, group_read_o;
    logic [14:0] grp_lvl, e;
    logic [5:0][7:0] analog_sel_o;
    logic sec_input_enable_o;
    int num_errors = 0;
    int total_checks = 0;
    row_type rows [16] = '{
        '{20'hF_0060, 8'h00, 1'b0, 3'h0, 8'hF0},
        '{20'hF_0063, 8'h00, 1'b0, 3'h0, 8'h1F},
        '{20'hF_006A, 8'h00, 1'b0, 3'h0, 8'hFE},
        '{20'hF_006B, 8'h00, 1'b0, 3'h0, 8'h1F},
        '{20'hF_006C, 8'h00, 1'b0, 3'h0, 8'hFE},
        '{20'hF_006E, 8'h00, 1'b0, 3'h0, 8'h7F},
        '{20'hF_0060, 8'h01, 1'b1, 3'h2, 8'hF4},
        '{20'hF_0060, 8'h00, 1'b1, 3'h7, 8'hF4},
        '{20'hF_0076, 8'h5A, 1'b0, 3'h0, 8'h0A},
        '{20'hF_0076, 8'h01, 1'b1, 3'h0, 8'h0A},
        '{20'hF_0077, 8'hFF, 1'b0, 3'h0, 8'h3F},
        '{20'hF_0077, 8'h00, 1'b1, 3'h0, 8'h3F},
        '{20'hF_007D, 8'hFF, 1'b0, 3'h0, 8'h01},
        '{20'hF_007D, 8'h00, 1'b1, 3'h0, 8'h00},
        '{20'hF_007D, 8'h01, 1'b1, 3'h3, 8'h00},
        '{20'hF_0061, 8'h55, 1'b0, 3'h0, 8'h00}};

    port_analog_redirect_config uut (.clk_sys_i, .resetn_i, .bus_i,
        .rdata_o, .func_enable_i, .group_dir_in_i, .group_pin_i,
        .sec_pin_i, .sec_open_drain_i, .analog_sel_o, .group_analog_o,
        .redirect_o, .sec_input_enable_o, .group_read_o, .sec_read_o);
    pin_side_model pins (.clk_sys_i(clk_sys_i), .supply_on_i(supply_on),
        .group_level_i(grp_lvl), .sec_level_i(8'hA5),
        .group_pin_o(group_pin_i), .sec_pin_o(sec_pin_i));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] s, x);
        total_checks++;
        if (s !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d,
                      input logic b, input logic [2:0] i);
        @(posedge clk_sys_i);
        bus_i <= '{1'b1, 1'b0, b, i, a, d};
        @(posedge clk_sys_i);
        bus_i <= '0;
    endtask
    // read data stands one cycle, so sample just after the taking edge
    task automatic rd(input logic [19:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        bus_i <= '{1'b0, 1'b1, 1'b0, 3'h0, a, 8'h00};
        @(posedge clk_sys_i);
        bus_i <= '0;
        #1 d = rdata_o;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic reset_vals();
        for (int k = 0; k < 6; k++) begin
            check("asel", analog_sel_o[k], 8'hFF);
        end
        check("grp", group_analog_o, 15'h7FFF);
        check("redir", redirect_o, 6'h00);
        check("in_en", sec_input_enable_o, 1'b1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        resetn_i = 1'b0;
        bus_i = '0;
        func_enable_i = 6'h00;
        group_dir_in_i = 15'h7FFF;
        grp_lvl = 15'h7FFF;
        sec_open_drain_i = 8'h0F;
        supply_on = 1'b1;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        settle(1);
        reset_vals();
        $display("test reset done");
        foreach (rows[n]) begin
            wr(rows[n].a, rows[n].d, rows[n].b, rows[n].i);
            rd(rows[n].a, v);
            check("rdback", v, rows[n].e);
        end
        check("asel0", analog_sel_o[0], 8'hF4);
        check("redir", redirect_o, 6'h3F);
        $display("test register table done");
        // codes walked in order, group pins held at one, analog pins in input mode
        for (int k = 0; k < 16; k++) begin
            e = (k == 0) ? 15'h7FFF : 15'((16'h0001 << (k - 1)) - 1);
            @(posedge clk_sys_i);
            // old and new analog pins input
            group_dir_in_i <= group_dir_in_i | e;
            wr(20'hF_0076, 8'(k), 1'b0, 3'h0);
            settle(3);
            @(posedge clk_sys_i);
            group_dir_in_i <= e | 15'h2AF5;
            settle(1);
            check("grp", group_analog_o, e);
            check("grp_rd", group_read_o, grp_lvl & ~e);
        end
        $display("test group code done");
        @(posedge clk_sys_i);
        func_enable_i <= 6'h01;
        wr(20'hF_0077, 8'h00, 1'b0, 3'h0);
        settle(3);
        check("redir_held", redirect_o, 6'h01);
        @(posedge clk_sys_i);
        func_enable_i <= 6'h00;
        settle(3);
        check("redir_free", redirect_o, 6'h00);
        $display("test redirection done");
        wr(20'hF_007D, 8'h01, 1'b1, 3'h0);
        @(posedge clk_sys_i);
        supply_on <= 1'b0;
        settle(4);
        check("in_en", sec_input_enable_o, 1'b0);
        check("sec_rd", sec_read_o, 8'hF0);
        settle(1);
        check("sec_rd", sec_read_o, 8'hF0);
        supply_on <= 1'b1;
        wr(20'hF_007D, 8'h00, 1'b1, 3'h0);
        settle(4);
        check("sec_rd", sec_read_o, 8'hA5);
        $display("test input block done");
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        settle(1);
        reset_vals();
        rd(20'hF_0076, v);
        check("grp_cfg", v, 8'h00);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
